// ---- hw/ccs_pkg.sv ----
package ccs_pkg;
    // Channel-relative register offsets (byte addresses on the local bus)
    localparam logic [3:0]  CCS_OFF_CONTROL   = 4'h0;
    localparam logic [3:0]  CCS_OFF_STATUS    = 4'h4;
    localparam int          CCS_NUM_CHANNELS  = 2;

    // Control register fields
    localparam int CTL_TX_RST      = 0;
    localparam int CTL_RX_RST      = 1;
    localparam int CTL_BYPASS      = 2;
    localparam int CTL_CHAN_IE     = 3;
    localparam int CTL_FORCE_INT   = 4;
    localparam int CTL_WR_DMA_IE   = 5;
    localparam int CTL_RD_DMA_IE   = 6;
    localparam int CTL_TX_URGENT   = 7;
    localparam int CTL_RX_URGENT   = 8;
    localparam int CTL_EXT_LOAD    = 12;
    localparam int CTL_EXT_ENABLE  = 13;
    localparam int CTL_EXT_PATH    = 14;
    localparam int CTL_DIRECTION   = 15;
    localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_F1FF;
    localparam logic [31:0] CTL_RESET      = 32'h0000_0000;

    // Status register fields
    localparam int ST_TX_EMPTY     = 0;
    localparam int ST_TX_AEMPTY    = 1;
    localparam int ST_TX_FULL      = 2;
    localparam int ST_RX_EMPTY     = 4;
    localparam int ST_RX_AFULL     = 5;
    localparam int ST_RX_FULL      = 6;
    localparam int ST_TX_LVL       = 8;
    localparam int ST_RX_LVL       = 9;
    localparam int ST_TX_LVL_LAT   = 10;
    localparam int ST_RX_LVL_LAT   = 11;
    localparam int ST_WR_DMA_ERR   = 12;
    localparam int ST_RD_DMA_ERR   = 13;
    localparam int ST_WR_DMA_INT   = 14;
    localparam int ST_RD_DMA_INT   = 15;
    localparam int ST_TX_IMG_DONE  = 16;
    localparam int ST_RX_IMG_DONE  = 17;
    localparam int ST_RX_OVERFLOW  = 18;
    localparam int ST_TX_UNDERFLOW = 19;
    localparam int ST_RX_IDLE      = 20;
    localparam int ST_TX_IDLE      = 21;
    localparam int ST_BO_IDLE      = 22;
    localparam int ST_BI_IDLE      = 23;
    localparam int ST_EXT_EMPTY    = 24;
    localparam int ST_EXT_AEMPTY   = 25;
    localparam int ST_EXT_AFULL    = 26;
    localparam int ST_EXT_FULL     = 27;
    localparam int ST_DIRECTION    = 28;
    localparam int ST_LOCAL_INT    = 30;
    localparam int ST_INT_STATUS   = 31;
    localparam logic [31:0] ST_STICKY_MASK = 32'h000F_FC00;
    localparam logic [31:0] ST_RESET       = 32'h0000_0000;

    typedef enum logic [1:0] {
        CCS_MV_IDLE  = 2'b00,
        CCS_MV_READ  = 2'b01,
        CCS_MV_WRITE = 2'b11
    } ccs_mover_e;
endpackage : ccs_pkg

// ---- hw/ccs_mover_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Loop-back mover handshake between a channel and its mover
interface ccs_mover_if;
    logic enable;
    logic src_empty;
    logic dst_full;
    logic src_read;
    logic dst_write;
    logic busy;
    modport chan  (output enable, output src_empty, output dst_full, input src_read, input dst_write, input busy);
    modport mover (input enable, input src_empty, input dst_full, output src_read, output dst_write, output busy);
endinterface : ccs_mover_if
`default_nettype wire

// ---- hw/ccs_mover.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccs_mover
    import ccs_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   sm_reset,
    // Buffer handshake
    ccs_mover_if.mover  mv
);
    typedef struct packed {
        ccs_mover_e state;
        logic       rd;
        logic       wr;
    } ccs_mover_s;

    ccs_mover_s st_r, st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.rd = 1'b0;
        st_nxt.wr = 1'b0;
        case (st_r.state)
            CCS_MV_IDLE: begin
                if (mv.enable && !mv.src_empty && !mv.dst_full) begin
                    st_nxt.rd    = 1'b1;
                    st_nxt.state = CCS_MV_READ;
                end
            end
            CCS_MV_READ: begin
                // One cycle for the source word to appear before it is written
                st_nxt.wr    = 1'b1;
                st_nxt.state = CCS_MV_WRITE;
            end
            CCS_MV_WRITE: begin
                st_nxt.state = CCS_MV_IDLE;
            end
            default: st_nxt.state = CCS_MV_IDLE;
        endcase
        if (sm_reset) begin
            st_nxt = '{state: CCS_MV_IDLE, rd: 1'b0, wr: 1'b0};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{state: CCS_MV_IDLE, rd: 1'b0, wr: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mv.src_read  = st_r.rd;
    assign mv.dst_write = st_r.wr;
    assign mv.busy      = (st_r.state != CCS_MV_IDLE);
endmodule : ccs_mover
`default_nettype wire

// ---- hw/ccs_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccs_channel
    import ccs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Channel-relative register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // Block events and levels
    input  wire logic [31:0] evt,
    input  wire logic        master_ie,
    input  wire logic        tx_enabled,
    input  wire logic        rx_enabled,
    // Outputs
    output logic      [31:0] ctl,
    output logic             local_int,
    output logic             int_req,
    output logic             tx_boost,
    output logic             rx_boost,
    output logic             loop_rd,
    output logic             loop_wr
);
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] sticky;
        logic [31:0] rdata;
        logic        local_int;
        logic        int_req;
        logic        tx_boost;
        logic        rx_boost;
    } ccs_chan_s;

    ccs_chan_s   st_r, st_nxt;
    logic [31:0] status_view;
    logic        sm_reset;

    ccs_mover_if mv ();

    assign sm_reset     = st_r.ctl[CTL_TX_RST] | st_r.ctl[CTL_RX_RST];
    assign mv.enable    = st_r.ctl[CTL_BYPASS] & ~tx_enabled & ~rx_enabled;
    assign mv.src_empty = evt[ST_TX_EMPTY];
    assign mv.dst_full  = evt[ST_RX_FULL];

    ccs_mover u_mover (
        .clk      (clk),
        .rst      (rst),
        .sm_reset (sm_reset),
        .mv       (mv.mover)
    );

    always_comb begin
        logic lint;
        logic dma_int;
        lint    = 1'b0;
        dma_int = 1'b0;
        st_nxt  = st_r;

        // Hardware set wins over a software clear in the same cycle
        if (reg_wr && reg_addr == CCS_OFF_CONTROL) begin
            st_nxt.ctl = reg_wdata & CTL_WRITE_MASK;
        end
        st_nxt.sticky = st_r.sticky;
        if (reg_wr && reg_addr == CCS_OFF_STATUS) begin
            st_nxt.sticky = st_r.sticky & ~(reg_wdata & ST_STICKY_MASK);
        end
        st_nxt.sticky = st_nxt.sticky | (evt & ST_STICKY_MASK);

        // DMA completion flags only count when their enables are set
        dma_int = (st_r.sticky[ST_WR_DMA_INT] & st_r.ctl[CTL_WR_DMA_IE])
                | (st_r.sticky[ST_RD_DMA_INT] & st_r.ctl[CTL_RD_DMA_IE]);
        lint = st_r.ctl[CTL_CHAN_IE] & (st_r.ctl[CTL_FORCE_INT]
             | st_r.sticky[ST_TX_LVL_LAT] | st_r.sticky[ST_RX_LVL_LAT]
             | st_r.sticky[ST_TX_IMG_DONE] | st_r.sticky[ST_RX_IMG_DONE]
             | st_r.sticky[ST_RX_OVERFLOW] | st_r.sticky[ST_TX_UNDERFLOW]);
        st_nxt.local_int = lint;
        st_nxt.int_req   = master_ie & (lint | dma_int);
        st_nxt.tx_boost  = st_r.ctl[CTL_TX_URGENT] & evt[ST_TX_AEMPTY];
        st_nxt.rx_boost  = st_r.ctl[CTL_RX_URGENT] & evt[ST_RX_AFULL];

        st_nxt.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == CCS_OFF_CONTROL) begin
                st_nxt.rdata = st_r.ctl;
            end else if (reg_addr == CCS_OFF_STATUS) begin
                st_nxt.rdata = status_view;
            end
        end
    end

    // Live bits come straight from the block; spare positions 3, 7, 29 read zero
    always_comb begin
        status_view = (evt & 32'h0FF0_0377) | st_r.sticky;
        status_view[ST_DIRECTION]  = st_r.ctl[CTL_DIRECTION];
        status_view[ST_LOCAL_INT]  = st_r.local_int;
        status_view[ST_INT_STATUS] = st_r.int_req;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{ctl: CTL_RESET, sticky: ST_RESET, rdata: 32'h0000_0000,
                      local_int: 1'b0, int_req: 1'b0, tx_boost: 1'b0, rx_boost: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign ctl       = st_r.ctl;
    assign local_int = st_r.local_int;
    assign int_req   = st_r.int_req;
    assign tx_boost  = st_r.tx_boost;
    assign rx_boost  = st_r.rx_boost;
    assign loop_rd   = mv.src_read;
    assign loop_wr   = mv.dst_write;
endmodule : ccs_channel
`default_nettype wire

// ---- hw/ccs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccs_top
    import ccs_pkg::*;
#(
    parameter int NCH = CCS_NUM_CHANNELS
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port, one select per channel
    input  wire logic [NCH-1:0]    chan_sel,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    // Block status inputs, per channel, laid out as the status word, plus the shared master enable
    input  wire logic [NCH*32-1:0] chan_events,
    input  wire logic [NCH-1:0]    tx_enabled,
    input  wire logic [NCH-1:0]    rx_enabled,
    input  wire logic              master_ie,
    // Per-channel controls
    output logic      [NCH-1:0]    tx_buffer_reset,
    output logic      [NCH-1:0]    rx_buffer_reset,
    output logic      [NCH-1:0]    pixel_sm_reset,
    output logic      [NCH-1:0]    transmit_dma_priority_boost,
    output logic      [NCH-1:0]    receive_dma_priority_boost,
    output logic      [NCH-1:0]    loop_read,
    output logic      [NCH-1:0]    loop_write,
    // External buffer and transceivers
    output logic      [NCH-1:0]    external_buffer_reset_n,
    output logic      [NCH-1:0]    external_buffer_offset_load,
    output logic      [NCH-1:0]    external_buffer_path_select,
    output logic      [NCH-1:0]    transceiver_transmit,
    // Board level
    output logic      [NCH-1:0]    board_channel_int,
    output logic                   host_int
);
    typedef struct packed {
        logic [31:0]    rdata;
        logic [NCH-1:0] board_int;
        logic           host_int;
    } ccs_top_s;

    ccs_top_s         st_r, st_nxt;
    logic [31:0]      ch_rdata [NCH];
    logic [31:0]      ch_ctl   [NCH];
    logic [NCH-1:0]   ch_lint, ch_ireq, ch_txb, ch_rxb, ch_lrd, ch_lwr;

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        ccs_channel u_chan (
            .clk        (clk),
            .rst        (rst),
            .reg_wr     (reg_wr & chan_sel[c]),
            .reg_rd     (reg_rd & chan_sel[c]),
            .reg_addr   (reg_addr),
            .reg_wdata  (reg_wdata),
            .reg_rdata  (ch_rdata[c]),
            .evt        (chan_events[c*32 +: 32]),
            .master_ie  (master_ie),
            .tx_enabled (tx_enabled[c]),
            .rx_enabled (rx_enabled[c]),
            .ctl        (ch_ctl[c]),
            .local_int  (ch_lint[c]),
            .int_req    (ch_ireq[c]),
            .tx_boost   (ch_txb[c]),
            .rx_boost   (ch_rxb[c]),
            .loop_rd    (ch_lrd[c]),
            .loop_wr    (ch_lwr[c])
        );
        assign tx_buffer_reset[c]             = ch_ctl[c][CTL_TX_RST];
        assign rx_buffer_reset[c]             = ch_ctl[c][CTL_RX_RST];
        assign pixel_sm_reset[c]              = ch_ctl[c][CTL_TX_RST] | ch_ctl[c][CTL_RX_RST];
        assign external_buffer_reset_n[c]     = ch_ctl[c][CTL_EXT_ENABLE];
        assign external_buffer_offset_load[c] = ch_ctl[c][CTL_EXT_LOAD];
        assign external_buffer_path_select[c] = ch_ctl[c][CTL_EXT_PATH];
        assign transceiver_transmit[c]        = ch_ctl[c][CTL_DIRECTION];
        assign transmit_dma_priority_boost[c] = ch_txb[c];
        assign receive_dma_priority_boost[c]  = ch_rxb[c];
        assign loop_read[c]                   = ch_lrd[c];
        assign loop_write[c]                  = ch_lwr[c];
    end

    always_comb begin
        st_nxt           = st_r;
        st_nxt.rdata     = 32'h0000_0000;
        for (int c = 0; c < NCH; c++) begin
            // Channel read data is already registered; unselected channels read zero, so all are ORed
            st_nxt.rdata = st_nxt.rdata | ch_rdata[c];
        end
        st_nxt.board_int = ch_lint;
        st_nxt.host_int  = |ch_ireq;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{rdata: 32'h0000_0000, board_int: '0, host_int: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata         = st_r.rdata;
    assign board_channel_int = st_r.board_int;
    assign host_int          = st_r.host_int;
endmodule : ccs_top
`default_nettype wire

// ---- tb/ccs_ext_buffer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccs_ext_buffer_model (
    // Control pins from the block
    input  wire logic   clk,
    input  wire logic   reset_n,
    input  wire logic   load,
    // Flags {full, almost full, almost empty, empty} and offset state
    output logic [3:0]  flags,
    output logic [9:0]  offset,
    output logic        loading
);
    // No data path: the buffer never leaves empty, so the flags stay fixed
    assign flags = 4'h3;
    // Load pin level while held in reset picks the default offset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            offset <= load ? 10'h3FF : 10'h07F;
        end
    end
    assign loading = reset_n & ~load;
endmodule : ccs_ext_buffer_model
`default_nettype wire

// ---- tb/ccs_top_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccs_top_chk #(
    parameter int NCH = 2
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [NCH-1:0]    chan_sel,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic [31:0]       reg_rdata,
    // Watched levels and outputs
    input  wire logic [NCH*32-1:0] chan_events,
    input  wire logic              master_ie,
    input  wire logic [NCH-1:0]    tx_buffer_reset,
    input  wire logic [NCH-1:0]    rx_buffer_reset,
    input  wire logic [NCH-1:0]    pixel_sm_reset,
    input  wire logic [NCH-1:0]    transmit_dma_priority_boost,
    input  wire logic [NCH-1:0]    receive_dma_priority_boost,
    input  wire logic [NCH-1:0]    loop_read,
    input  wire logic [NCH-1:0]    loop_write,
    input  wire logic [NCH-1:0]    external_buffer_reset_n,
    input  wire logic [NCH-1:0]    external_buffer_offset_load,
    input  wire logic [NCH-1:0]    external_buffer_path_select,
    input  wire logic [NCH-1:0]    transceiver_transmit,
    input  wire logic              host_int
);
    logic       wr0;
    logic [1:0] urg_r;
    assign wr0 = reg_wr && chan_sel[0] && reg_addr == 4'h0;
    // Shadow of channel 0 priority bits so the boost timing can be tied to its cause
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            urg_r <= 2'h0;
        end else if (wr0) begin
            urg_r <= reg_wdata[8:7];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ctl_write: assert property (
        wr0 |=> {rx_buffer_reset[0], tx_buffer_reset[0]} == $past(reg_wdata[1:0]))
        else $error("buffer reset bits differ from written control");
    a_ext_pins: assert property (
        wr0 |=> {transceiver_transmit[0], external_buffer_path_select[0], external_buffer_reset_n[0],
                 external_buffer_offset_load[0]} == $past(reg_wdata[15:12]))
        else $error("external pins differ from written control");
    a_sm_reset: assert property (
        pixel_sm_reset == (tx_buffer_reset | rx_buffer_reset))
        else $error("state machine reset not tied to buffer resets");
    a_tx_boost: assert property (
        transmit_dma_priority_boost[0] == $past(urg_r[0] & chan_events[1]))
        else $error("transmit boost wrong");
    a_rx_boost: assert property (
        receive_dma_priority_boost[0] == $past(urg_r[1] & chan_events[5]))
        else $error("receive boost wrong");
    a_host_gate: assert property (
        !master_ie [*3] |=> !host_int)
        else $error("host interrupt without master enable");
    a_rdata_idle: assert property (
        !reg_rd |-> ##2 reg_rdata == 32'h0000_0000)
        else $error("read data not zero without read");
    a_loop_order: assert property (
        loop_write[0] |-> $past(loop_read[0]))
        else $error("mover write without prior read");
    a_loop_spacing: assert property (
        loop_read[0] |=> !loop_read[0] [*2])
        else $error("mover reads too close");
    c_ctl_write: cover property (wr0);
    c_loop_move: cover property (loop_write[0]);
    c_host_int: cover property (host_int);
endmodule : ccs_top_chk
bind ccs_top ccs_top_chk #(.NCH(NCH)) ccs_top_chk_inst (.clk, .rst, .chan_sel, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .chan_events, .master_ie, .tx_buffer_reset, .rx_buffer_reset, .pixel_sm_reset,
    .transmit_dma_priority_boost, .receive_dma_priority_boost, .loop_read, .loop_write, .external_buffer_reset_n,
    .external_buffer_offset_load, .external_buffer_path_select, .transceiver_transmit, .host_int);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ccs_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        reg_wr;
    logic        reg_rd;
    logic        master_ie;
    logic        host_int;
    logic [1:0]  chan_sel;
    logic [1:0]  tx_en;
    logic [1:0]  rx_en;
    logic [1:0]  txr, rxr, smr, txb, rxb, lrd, lwr, ern, eld, eps, ttx, bci;
    logic [3:0]  reg_addr;
    logic [3:0]  ext_flags;
    logic [9:0]  ext_offset;
    logic        ext_loading;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [63:0] ev;
    logic [63:0] chan_events;
    int          fail_count = 0;
    int          n_tests = 0;
    assign chan_events = ev | {36'h0, ext_flags, 24'h0};
    ccs_top ccs_top_inst (
        .clk(clk), .rst(rst), .chan_sel(chan_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chan_events(chan_events), .tx_enabled(tx_en),
        .rx_enabled(rx_en), .master_ie(master_ie), .tx_buffer_reset(txr), .rx_buffer_reset(rxr),
        .pixel_sm_reset(smr), .transmit_dma_priority_boost(txb), .receive_dma_priority_boost(rxb),
        .loop_read(lrd), .loop_write(lwr), .external_buffer_reset_n(ern), .external_buffer_offset_load(eld),
        .external_buffer_path_select(eps), .transceiver_transmit(ttx), .board_channel_int(bci), .host_int(host_int));
    // Partner hangs on channel 0; channel 1 external pins are judged at the ports
    ccs_ext_buffer_model ccs_ext_buffer_model_inst (
        .clk(clk), .reset_n(ern[0]), .load(eld[0]), .flags(ext_flags), .offset(ext_offset), .loading(ext_loading));
    task automatic final_report();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic access(input logic [1:0] s, input logic w, input logic [3:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(negedge clk);
        chan_sel  = s;
        reg_wr    = w;
        reg_rd    = ~w;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        @(negedge clk);
        q = reg_rdata;
    endtask : access
    task automatic wr(input logic [1:0] s, input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(s, 1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input logic [1:0] s, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        access(s, 1'b0, a, 32'h0, q);
        chk(e, q & m);
    endtask : rdchk
    task automatic pulse(input logic [31:0] b);
        @(negedge clk);
        ev[31:0] = ev[31:0] | b;
        @(negedge clk);
        ev[31:0] = ev[31:0] & ~b;
    endtask : pulse
    task automatic t_ctl();
        wr(2'b01, 4'h0, 32'hFFFF_FFFF);
        rdchk(2'b01, 4'h0, 32'hFFFF_FFFF, 32'h0000_F1FF);
        chk(32'h0000_5554, {16'h0, ttx, eps, ern, eld, txr, rxr, smr, lrd});
        wr(2'b10, 4'h0, 32'h0000_8001);
        rdchk(2'b10, 4'h0, 32'hFFFF_FFFF, 32'h0000_8001);
        rdchk(2'b01, 4'h8, 32'hFFFF_FFFF, 32'h0000_0000);
        chk(32'h0000_000D, {28'h0, ttx[1], txr[1], rxr[1], smr[1]});
        wr(2'b01, 4'h0, 32'h0000_1000);
        wr(2'b01, 4'h0, 32'h0000_3000);
        chk(32'h0000_03FF, {21'h0, ext_loading, ext_offset});
        wr(2'b01, 4'h0, 32'h0000_0000);
        wr(2'b01, 4'h0, 32'h0000_2000);
        chk(32'h0000_047F, {21'h0, ext_loading, ext_offset});
    endtask : t_ctl
    task automatic t_status();
        ev[31:0] = 32'h20F0_00AD;
        wr(2'b01, 4'h0, 32'h0000_A000);
        pulse(32'h0009_3000);
        rdchk(2'b01, 4'h4, 32'h3FFF_FFFF, 32'h13F9_3025);
        rdchk(2'b10, 4'h4, 32'h000F_F077, 32'h0000_0000);
        wr(2'b01, 4'h4, 32'h0000_0000);
        rdchk(2'b01, 4'h4, 32'h3FFF_FFFF, 32'h13F9_3025);
        wr(2'b01, 4'h4, 32'h0001_2000);
        rdchk(2'b01, 4'h4, 32'h3FFF_FFFF, 32'h13F8_1025);
    endtask : t_status
    task automatic t_int();
        wr(2'b01, 4'h4, 32'hFFFF_FFFF);
        master_ie = 1'b1;
        wr(2'b01, 4'h0, 32'h0000_2018);
        repeat (4) @(negedge clk);
        chk(32'h5, {29'h0, host_int, bci});
        rdchk(2'b01, 4'h4, 32'hC000_0000, 32'hC000_0000);
        wr(2'b01, 4'h0, 32'h0000_2010);
        repeat (4) @(negedge clk);
        chk(32'h0, {29'h0, host_int, bci});
        wr(2'b01, 4'h0, 32'h0000_2020);
        pulse(32'h0000_4000);
        repeat (4) @(negedge clk);
        chk(32'h4, {29'h0, host_int, bci});
        rdchk(2'b01, 4'h4, 32'h0000_C000, 32'h0000_4000);
        wr(2'b01, 4'h0, 32'h0000_2000);
        repeat (4) @(negedge clk);
        chk(32'h0, {29'h0, host_int, bci});
        wr(2'b01, 4'h0, 32'h0000_2018);
        master_ie = 1'b0;
        repeat (4) @(negedge clk);
        chk(32'h1, {29'h0, host_int, bci});
        wr(2'b01, 4'h0, 32'h0000_2000);
        wr(2'b10, 4'h0, 32'h0000_8018);
        repeat (4) @(negedge clk);
        chk(32'h2, {29'h0, host_int, bci});
        wr(2'b10, 4'h0, 32'h0000_8001);
    endtask : t_int
    task automatic t_boost();
        wr(2'b01, 4'h0, 32'h0000_2180);
        ev[1] = 1'b1;
        repeat (2) @(negedge clk);
        chk(32'h5, {28'h0, txb, rxb});
        wr(2'b01, 4'h0, 32'h0000_2000);
        chk(32'h0, {28'h0, txb, rxb});
        ev[1] = 1'b0;
    endtask : t_boost
    task automatic t_loop();
        int nr;
        int nw;
        ev[0] = 1'b0;
        wr(2'b01, 4'h0, 32'h0000_2004);
        // Pass 1 enables the receiver, pass 2 empties the source, pass 3 fills the destination
        for (int k = 0; k < 4; k++) begin
            tx_en = 2'b00;
            rx_en = {1'b0, k == 1};
            ev[0] = (k == 2);
            ev[6] = (k == 3);
            nr = 0;
            nw = 0;
            repeat (3) @(negedge clk);
            repeat (12) begin
                @(negedge clk);
                nr += int'(lrd[0] === 1'b1);
                nw += int'(lwr[0] === 1'b1);
            end
            chk((k != 0) ? 32'h0 : 32'h0004_0004, {nr[15:0], nw[15:0]});
        end
    endtask : t_loop
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        final_report();
    end
    initial begin
        rst       = 1'b1;
        chan_sel  = 2'b00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        ev        = 64'h0;
        tx_en     = 2'b11;
        rx_en     = 2'b11;
        master_ie = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_ctl();
        t_status();
        t_int();
        t_boost();
        t_loop();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
